// [src/ptp_pkg.sv]
package ptp_pkg;
  // task word bit positions, bit 0 is the most significant
  localparam int TW_BRK_ABORT = 15 - 6;
  localparam int TW_KEEP_ON   = 15 - 9;
  localparam int TW_DATA_KIND = 15 - 10;
  localparam int CTL_STOP     = 15 - 1;
  localparam logic [15:0] TASK_RESET = 16'h0000;
  localparam logic [15:0] TAPE_OFF_RESET = 16'h0013;
  localparam int CLK_HZ   = 125_000_000;
  localparam int BAUD     = 110;
  localparam int BIT_CYC  = CLK_HZ / BAUD;
  localparam int STOP_BITS_DEF = 1;

  typedef enum logic [2:0] {
    CMD_TASK   = 3'h0,
    CMD_ADDR   = 3'h1,
    CMD_STATUS = 3'h2,
    CMD_CTL    = 3'h3,
    CMD_CFG_B  = 3'h4
  } cmd_e;

  typedef struct packed {
    logic       busy;
    logic       brk_seen;
    logic       stopped;
    logic       range_done;
    logic       data_kind;
    logic [10:0] unused;
  } status_s;
endpackage : ptp_pkg

// [src/ptp_buf2.sv]
`timescale 1ns/1ps
module ptp_buf2
  import ptp_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         CLOCK_I,
  input  wire logic         RST_B_I,
  input  wire logic         in_valid_i,
  output wire logic         in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output wire logic         out_valid_o,
  input  wire logic         out_ready_i,
  output wire logic [W-1:0] out_data_o
);
  logic [W-1:0] mem [2];
  logic         wp;
  logic         rp;
  logic [1:0]   cnt;
  wire          push = in_valid_i && in_ready_o;
  wire          pop  = out_valid_o && out_ready_i;
  assign in_ready_o  = (cnt != 2'h2);
  assign out_valid_o = (cnt != 2'h0);
  assign out_data_o  = mem[rp];
  always_ff @(posedge CLOCK_I or negedge RST_B_I)
    if (!RST_B_I)
    begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end
    else
    begin
      if (push) wp <= ~wp;
      if (pop) rp <= ~rp;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  always_ff @(posedge CLOCK_I)
    if (push) mem[wp] <= in_data_i;
endmodule : ptp_buf2

// [src/ptp_uart_tx.sv]
`timescale 1ns/1ps
module ptp_uart_tx
  import ptp_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC
)(
  input  wire logic       CLOCK_I,
  input  wire logic       RST_B_I,
  input  wire logic       two_stop_i,
  input  wire logic       valid_i,
  output wire logic       ready_o,
  input  wire logic [7:0] data_i,
  output logic            txd_o
);
  logic [10:0] sh;
  logic [3:0]  left;
  logic [$clog2(BIT_CYCLES+1)-1:0] tick;
  assign ready_o = (left == 4'h0);
  // start, 8 data lsb first, one or two stop bits
  always_ff @(posedge CLOCK_I or negedge RST_B_I)
    if (!RST_B_I)
    begin
      sh    <= '1;
      left  <= 4'h0;
      tick  <= '0;
      txd_o <= 1'b1;
    end
    else if (valid_i && ready_o)
    begin
      sh    <= {2'b11, data_i, 1'b0};
      left  <= two_stop_i ? 4'hB : 4'hA;
      tick  <= '0;
      txd_o <= 1'b0;
    end
    else if (left != 4'h0)
    begin
      if (tick == $bits(tick)'(BIT_CYCLES - 1))
      begin
        tick  <= '0;
        left  <= left - 4'h1;
        sh    <= {1'b1, sh[10:1]};
        txd_o <= (left == 4'h1) ? 1'b1 : sh[1];
      end
      else
        tick <= tick + 1'b1;
    end
endmodule : ptp_uart_tx

// [src/ptp_punch.sv]
`timescale 1ns/1ps
//
// Contract
// [R1] address-and-range load on odd channel starts a punch operation
// [R2] task bit 6 picks log-only or abort output on break
// [R3] bit 9 zero and range zero sends control char 3, tape off
// [R4] task bit 10 chooses data kind; reported in status
// [R5] software writes zeros to bits 12-15 and must-be-zero bits
// [R6] software starts punch itself with tape-on and delete chars
// [R7] normal end: stop punch if asked, go idle, interrupt if allowed
// [R8] stop I/O or break while punching: stop punch, idle, interrupt
// [R9] status input command answers with current status word
// [R10] software polls status or waits for interrupt
// [R11] control command with stop bit one ends order, idle, interrupt
// [R12] serial link at 110 baud, one or two stop bits
// [R13] task command precedes load; task kept over a series
// [R14] busy shown in indicator bit with status
// [R15] data commands refused while busy, control command accepted
module ptp_punch
  import ptp_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC
)(
  input  wire logic        CLOCK_I,
  input  wire logic        RST_B_I,
  input  wire logic        CMD_VALID_I,
  input  wire logic [2:0]  CMD_CODE_I,
  input  wire logic        CMD_CHAN_LSB_I,
  input  wire logic [15:0] CMD_DATA_I,
  output logic             CMD_ACK_O,
  output logic             CMD_NAK_O,
  output logic [15:0]      STATUS_O,
  output logic             BUSY_IND_O,
  input  wire logic        INT_ALLOW_I,
  output logic             INT_O,
  input  wire logic        BYTE_VALID_I,
  output wire logic        BYTE_READY_O,
  input  wire logic [7:0]  BYTE_I,
  input  wire logic        BREAK_I,
  input  wire logic        TWO_STOP_I,
  output wire logic        TXD_O
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_OFF  = 2'b10,
    ST_DRN  = 2'b11
  } st_e;

  st_e          st;
  st_e          next_st;
  logic [15:0]  task_word;
  logic [15:0]  range;
  logic [7:0]   tape_off;
  logic         brk_seen;
  logic         stopped;
  logic         range_done;
  logic         want_off;

  function automatic logic code_is(input logic [2:0] code, input cmd_e want);
    code_is = (code == want);
  endfunction : code_is

  wire is_cmd  = CMD_VALID_I;
  wire c_task  = is_cmd && code_is(CMD_CODE_I, CMD_TASK);
  wire c_addr  = is_cmd && code_is(CMD_CODE_I, CMD_ADDR) && CMD_CHAN_LSB_I;
  wire c_stat  = is_cmd && code_is(CMD_CODE_I, CMD_STATUS);
  wire c_ctl   = is_cmd && code_is(CMD_CODE_I, CMD_CTL);
  wire c_cfg   = is_cmd && code_is(CMD_CODE_I, CMD_CFG_B);
  wire busy    = (st != ST_IDLE);
  wire refuse  = busy && (c_task || c_addr || c_cfg); // R15
  wire stop_rq = c_ctl && CMD_DATA_I[CTL_STOP]; // R11
  wire brk_abt = BREAK_I && task_word[TW_BRK_ABORT]; // R2

  // data path: source -> 2-entry buffer -> serialiser
  logic       b_valid;
  logic       b_ready;
  logic [7:0] b_data;
  logic       tx_ready;
  wire        run      = (st == ST_RUN);
  wire        src_v    = run && BYTE_VALID_I && range != 16'h0000;
  wire        src_r;
  wire        send_off = (st == ST_OFF) && !b_valid;
  assign BYTE_READY_O = run && range != 16'h0000 && src_r;
  wire        take     = src_v && src_r;
  wire        tx_v     = send_off ? 1'b1 : b_valid;
  wire [7:0]  tx_d     = send_off ? tape_off : b_data;
  assign b_ready = tx_ready;

  ptp_buf2 #(.W(8)) u_buf (
    .CLOCK_I     (CLOCK_I),
    .RST_B_I     (RST_B_I),
    .in_valid_i  (src_v),
    .in_ready_o  (src_r),
    .in_data_i   (BYTE_I),
    .out_valid_o (b_valid),
    .out_ready_i (b_ready),
    .out_data_o  (b_data)
  );

  ptp_uart_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx ( // R12
    .CLOCK_I    (CLOCK_I),
    .RST_B_I    (RST_B_I),
    .two_stop_i (TWO_STOP_I),
    .valid_i    (tx_v),
    .ready_o    (tx_ready),
    .data_i     (tx_d),
    .txd_o      (TXD_O)
  );

  wire drained = !b_valid && tx_ready;
  wire abort   = stop_rq || brk_abt; // R8

  always_comb
  begin
    next_st = st;
    unique case (st)
      ST_IDLE:
        if (c_addr && CMD_DATA_I != 16'h0000)
          next_st = ST_RUN; // R1
      ST_RUN:
        if (abort)
          next_st = ST_DRN;
        else if (range == 16'h0000 && !b_valid)
          next_st = want_off ? ST_OFF : ST_DRN; // R3
      ST_OFF:
        if (tx_ready && !b_valid)
          next_st = ST_DRN;
      ST_DRN:
        if (drained && !b_valid)
          next_st = ST_IDLE; // R7
    endcase
  end

  // abort drains accepted bytes, then sends tape-off to stop the punch
  always_ff @(posedge CLOCK_I or negedge RST_B_I)
    if (!RST_B_I)
    begin
      st         <= ST_IDLE;
      task_word  <= TASK_RESET;
      tape_off   <= TAPE_OFF_RESET[7:0];
      range      <= 16'h0000;
      brk_seen   <= 1'b0;
      stopped    <= 1'b0;
      range_done <= 1'b0;
      want_off   <= 1'b0;
    end
    else
    begin
      st <= (st == ST_RUN && abort) ? ST_OFF : next_st; // R8
      if (c_task && !busy)
        task_word <= CMD_DATA_I; // R13
      if (c_cfg && !busy)
        tape_off <= CMD_DATA_I[7:0];
      if (c_addr && !busy)
      begin
        range      <= CMD_DATA_I;
        brk_seen   <= 1'b0;
        stopped    <= 1'b0;
        range_done <= 1'b0;
        want_off   <= !task_word[TW_KEEP_ON]; // R3
      end
      else if (take)
        range <= range - 16'h0001;
      if (run && BREAK_I)
        brk_seen <= 1'b1; // R2
      if (run && abort)
      begin
        stopped <= 1'b1; // R11
        range   <= 16'h0000;
      end
      if (run && range == 16'h0000 && !abort)
        range_done <= 1'b1;
    end

  status_s sw;
  always_comb
  begin
    sw            = '0;
    sw.busy       = busy; // R14
    sw.brk_seen   = brk_seen;
    sw.stopped    = stopped;
    sw.range_done = range_done;
    sw.data_kind  = task_word[TW_DATA_KIND]; // R4
  end

  wire finish = (st == ST_DRN) && (next_st == ST_IDLE);

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
    if (!RST_B_I)
    begin
      CMD_ACK_O  <= 1'b0;
      CMD_NAK_O  <= 1'b0;
      STATUS_O   <= 16'h0000;
      BUSY_IND_O <= 1'b0;
      INT_O      <= 1'b0;
    end
    else
    begin
      CMD_ACK_O  <= is_cmd && !refuse; // R15
      CMD_NAK_O  <= refuse;
      BUSY_IND_O <= (next_st != ST_IDLE); // R14
      if (c_stat)
        STATUS_O <= sw; // R9
      INT_O <= finish && INT_ALLOW_I; // R7
    end

  // command answer checks
  chk_nak_busy: assert property ( // R15
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (busy && c_addr) |=> CMD_NAK_O && !CMD_ACK_O)
    else $error("load accepted while busy");
  chk_ctl_ack: assert property ( // R15
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (busy && c_ctl) |=> CMD_ACK_O)
    else $error("control refused while busy");
  chk_cmd_answer: assert property ( // R15
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    is_cmd |=> CMD_ACK_O != CMD_NAK_O)
    else $error("command not answered once");
  chk_task_held: assert property ( // R13
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (busy && c_task) |=> task_word == $past(task_word))
    else $error("task word changed while busy");
  chk_status_rd: assert property ( // R9
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    c_stat |=> STATUS_O[15] == $past(busy))
    else $error("status busy bit wrong");
  chk_status_hold: assert property ( // R9
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    !c_stat |=> $stable(STATUS_O))
    else $error("status word changed without command");
  chk_data_kind: assert property ( // R4
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    c_stat |=> STATUS_O[11] == $past(task_word[TW_DATA_KIND]))
    else $error("data kind not reported");
  chk_busy_ind: assert property ( // R14
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    BUSY_IND_O == busy)
    else $error("busy indicator wrong");

  // start and transfer checks
  chk_start_run: assert property ( // R1
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (!busy && c_addr && CMD_DATA_I != 16'h0000) |=> st == ST_RUN)
    else $error("load did not start punch");
  chk_idle_load: assert property ( // R1
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (c_addr && !busy && CMD_DATA_I == 16'h0000) |=> !busy)
    else $error("empty range started punch");
  chk_ignore_lsb: assert property ( // R1
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (is_cmd && code_is(CMD_CODE_I, CMD_ADDR) && !CMD_CHAN_LSB_I && !busy)
      |=> !busy)
    else $error("input channel load started punch");
  chk_no_src_idle: assert property ( // R1
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    !run |-> !BYTE_READY_O)
    else $error("data taken outside a punch");
  chk_range_step: assert property ( // R7
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (take && !abort) |=> range == $past(range) - 16'h0001)
    else $error("range not counted down");

  // termination checks
  chk_tape_off: assert property ( // R3
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (run && range == 16'h0000 && !b_valid && !abort && want_off)
      |=> st == ST_OFF)
    else $error("tape off not sent");
  chk_keep_on: assert property ( // R3
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (run && range == 16'h0000 && !b_valid && !abort && !want_off)
      |=> st == ST_DRN)
    else $error("tape off sent in keep-on mode");
  chk_abort_off: assert property ( // R8
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (run && abort) |=> st == ST_OFF && stopped)
    else $error("abort did not stop punch");
  chk_abort_range: assert property ( // R8
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (run && abort) |=> range == 16'h0000)
    else $error("abort left range pending");
  chk_stop_cmd: assert property ( // R11
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (run && stop_rq) |=> stopped)
    else $error("stop command ignored");
  chk_break_log: assert property ( // R2
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (run && BREAK_I && !task_word[TW_BRK_ABORT] && !stop_rq)
      |=> st != ST_OFF || $past(range) == 16'h0000)
    else $error("break aborted in log mode");
  chk_log_flag: assert property ( // R2
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (run && BREAK_I) |=> brk_seen)
    else $error("break not recorded");
  chk_int_done: assert property ( // R7
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    INT_O |-> !BUSY_IND_O ##0 $past(INT_ALLOW_I))
    else $error("interrupt without completion");
  chk_int_pulse: assert property ( // R7
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (finish && INT_ALLOW_I) |=> INT_O)
    else $error("completion interrupt missing");
  chk_int_gate: assert property ( // R7
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (finish && !INT_ALLOW_I) |=> !INT_O)
    else $error("interrupt raised while not permitted");
  chk_idle_line: assert property ( // R12
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (!busy && tx_ready) |-> TXD_O)
    else $error("serial line not idle high");

  cov_punch_done: cover property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    finish && range_done);
  cov_stop_io: cover property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    run && stop_rq);
  cov_break_abt: cover property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    run && brk_abt);
  cov_stall: cover property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    run && BYTE_VALID_I && !src_r);
  cov_keep_on: cover property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    finish && !want_off);
endmodule : ptp_punch

// [sim/ptp_teleprinter_model.sv]
`timescale 1ns/1ps
module ptp_teleprinter_model
#(
  parameter int BIT_CYCLES = 4
)(
  input  wire logic CLOCK_I,
  input  wire logic txd_i,
  input  wire logic two_stop_i
);
  logic [7:0] rx_q[$];
  int         n_frame_err = 0;
  logic [7:0] sh;

  // receive one frame per start edge, sampling at bit centres
  always
  begin
    @(negedge txd_i);
    repeat (BIT_CYCLES / 2) @(posedge CLOCK_I);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYCLES) @(posedge CLOCK_I);
      sh[i] = txd_i;
    end
    repeat (BIT_CYCLES) @(posedge CLOCK_I);
    if (txd_i !== 1'b1)
      n_frame_err++;
    if (two_stop_i === 1'b1)
    begin
      repeat (BIT_CYCLES) @(posedge CLOCK_I);
      if (txd_i !== 1'b1)
        n_frame_err++;
    end
    rx_q.push_back(sh);
  end
endmodule : ptp_teleprinter_model

// [sim/paper_tape_punch_attachment_tb_top.sv]
`timescale 1ns/1ps
module paper_tape_punch_attachment_tb_top;
  import ptp_pkg::*;
  localparam int BITC = 4;
  logic        CLOCK_I = 1'b0;
  logic        RST_B_I = 1'b0;
  logic        CMD_VALID_I = 1'b0;
  logic [2:0]  CMD_CODE_I = 3'h0;
  logic        CMD_CHAN_LSB_I = 1'b0;
  logic [15:0] CMD_DATA_I = 16'h0000;
  logic        INT_ALLOW_I = 1'b1;
  logic        BYTE_VALID_I = 1'b0;
  logic [7:0]  BYTE_I = 8'h00;
  logic        BREAK_I = 1'b0;
  logic        TWO_STOP_I = 1'b0;
  logic        CMD_ACK_O, CMD_NAK_O, BUSY_IND_O, INT_O, BYTE_READY_O, TXD_O;
  logic [15:0] STATUS_O;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_int = 0;
  int          cyc = 0;

  always #4 CLOCK_I = ~CLOCK_I;

  ptp_punch #(.BIT_CYCLES(BITC)) uut (.*);
  ptp_teleprinter_model #(.BIT_CYCLES(BITC)) tp (
    .CLOCK_I    (CLOCK_I),
    .txd_i      (TXD_O),
    .two_stop_i (TWO_STOP_I)
  );

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  always @(posedge CLOCK_I)
  begin
    cyc <= cyc + 1;
    if (INT_O === 1'b1)
      n_int <= n_int + 1;
    if (cyc == 10000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one command; answer lands the cycle after it is taken
  task automatic cmd(input cmd_e c, input logic lsb, input logic [15:0] d,
                     input logic ack);
    @(posedge CLOCK_I);
    CMD_VALID_I <= 1'b1;
    CMD_CODE_I <= c;
    CMD_CHAN_LSB_I <= lsb;
    CMD_DATA_I <= d;
    @(posedge CLOCK_I);
    CMD_VALID_I <= 1'b0;
    #1;
    check({CMD_ACK_O, CMD_NAK_O}, {ack, ~ack});
  endtask : cmd

  task automatic put(input logic [7:0] b);
    int n = 0;
    @(posedge CLOCK_I);
    BYTE_I <= b;
    BYTE_VALID_I <= 1'b1;
    do
      @(negedge CLOCK_I);
    while (BYTE_READY_O !== 1'b1 && ++n < 2000);
    @(posedge CLOCK_I);
    BYTE_VALID_I <= 1'b0;
  endtask : put

  // wait for idle, then count interrupt pulses seen
  task automatic finish_op(input int ints);
    int n0 = n_int;
    int k = 0;
    while (BUSY_IND_O !== 1'b0 && k++ < 3000)
      @(posedge CLOCK_I);
    repeat (3) @(posedge CLOCK_I);
    #1;
    check(16'(n_int - n0), 16'(ints));
  endtask : finish_op

  task automatic check_rx(input logic [7:0] e[$]);
    check(16'(tp.rx_q.size()), 16'(e.size()));
    foreach (e[i])
      if (i < tp.rx_q.size())
        check({8'h00, tp.rx_q[i]}, {8'h00, e[i]});
    tp.rx_q.delete();
  endtask : check_rx

  task automatic check_last_off(input logic [7:0] e);
    check({8'h00, tp.rx_q[$]}, {8'h00, e});
    tp.rx_q.delete();
  endtask : check_last_off

  initial
  begin
    repeat (4) @(posedge CLOCK_I);
    RST_B_I <= 1'b1;
    #1;
    check({14'h0000, TXD_O, BUSY_IND_O}, 16'h0002);
    $display("test reset done");
    cmd(CMD_TASK, 1'b0, 16'h0001 << TW_DATA_KIND, 1'b1);
    cmd(CMD_ADDR, 1'b1, 16'h0003, 1'b1);
    check({15'h0000, BUSY_IND_O}, 16'h0001);
    cmd(CMD_TASK, 1'b0, 16'h0000, 1'b0);
    @(posedge CLOCK_I);
    BREAK_I <= 1'b1;
    put(8'h12);
    put(8'h7F);
    put(8'h55);
    finish_op(1);
    check_rx('{8'h12, 8'h7F, 8'h55, TAPE_OFF_RESET[7:0]});
    cmd(CMD_STATUS, 1'b0, 16'h0000, 1'b1);
    check(STATUS_O & 16'hF800, 16'h5800);
    @(posedge CLOCK_I);
    BREAK_I <= 1'b0;
    $display("test normal punch done");
    cmd(CMD_ADDR, 1'b0, 16'h0002, 1'b1);
    check({15'h0000, BUSY_IND_O}, 16'h0000);
    @(posedge CLOCK_I);
    INT_ALLOW_I <= 1'b0;
    TWO_STOP_I <= 1'b1;
    cmd(CMD_TASK, 1'b0, 16'h0001 << TW_KEEP_ON, 1'b1);
    cmd(CMD_ADDR, 1'b1, 16'h0001, 1'b1);
    cmd(CMD_STATUS, 1'b0, 16'h0000, 1'b1);
    check(STATUS_O & 16'h8000, 16'h8000);
    put(8'h41);
    finish_op(0);
    check_rx('{8'h41});
    $display("test polled keep-on done");
    @(posedge CLOCK_I);
    INT_ALLOW_I <= 1'b1;
    TWO_STOP_I <= 1'b0;
    cmd(CMD_ADDR, 1'b1, 16'h0003, 1'b1);
    put(8'h66);
    cmd(CMD_CTL, 1'b0, 16'h0001 << CTL_STOP, 1'b1);
    finish_op(1);
    check_last_off(TAPE_OFF_RESET[7:0]);
    cmd(CMD_STATUS, 1'b0, 16'h0000, 1'b1);
    check(STATUS_O & 16'hA000, 16'h2000);
    $display("test stop done");
    cmd(CMD_CFG_B, 1'b0, 16'h0014, 1'b1);
    cmd(CMD_TASK, 1'b0, 16'h0001 << TW_BRK_ABORT, 1'b1);
    cmd(CMD_ADDR, 1'b1, 16'h0004, 1'b1);
    cmd(CMD_CFG_B, 1'b0, 16'h0055, 1'b0);
    @(posedge CLOCK_I);
    BREAK_I <= 1'b1;
    finish_op(1);
    check_last_off(8'h14);
    cmd(CMD_STATUS, 1'b0, 16'h0000, 1'b1);
    check(STATUS_O & 16'hE000, 16'h6000);
    check(16'(tp.n_frame_err), 16'h0000);
    $display("test break abort done");
    complete_run();
  end
endmodule : paper_tape_punch_attachment_tb_top
